// ### rtl/pmr_regs.sv
// register bank: identification, program number and event groups
`timescale 1ns/1ps
`default_nettype none
module pmr_regs (
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               reset_n,
	// register port from the serial slave
	input  wire pmr_pkg::pmr_req_s  req,
	output logic              [7:0] rdata,
	// device state and reset classes
	input  wire pmr_pkg::pmr_ctl_s  ctl,
	input  wire logic        [11:0] otp_program_number,
	input  wire logic         [7:0] otp_trial_default,
	// event sources, one byte per group
	input  wire logic         [7:0] ev_sys,
	input  wire logic         [7:0] ev_thm,
	input  wire logic         [7:0] ev_bmd,
	input  wire logic         [7:0] ev_bil,
	input  wire logic         [7:0] ev_lil,
	input  wire logic         [7:0] ev_buv,
	input  wire logic         [7:0] ev_bov,
	input  wire logic         [7:0] ev_luv,
	input  wire logic               soft_wdog_done,
	// live sense levels
	input  wire logic         [7:0] live_sys,
	input  wire logic         [7:0] live_thm,
	input  wire logic         [7:0] live_bil,
	input  wire logic         [7:0] live_lil,
	input  wire logic         [7:0] live_buv,
	input  wire logic         [7:0] live_bov,
	input  wire logic         [7:0] live_luv,
	// outputs
	output logic              [7:0] trial_setting,
	output logic                    interrupt_out_n
);

	localparam int G = pmr_pkg::PMR_GROUPS;

	// ----------------------------------------------------------------
	// group tables
	// ----------------------------------------------------------------
	localparam logic [7:0] FLAG_ADDR [G] = '{
		pmr_pkg::PMR_ADDR_SYS_FLAG, pmr_pkg::PMR_ADDR_THM_FLAG,
		pmr_pkg::PMR_ADDR_BMD_FLAG, pmr_pkg::PMR_ADDR_BIL_FLAG,
		pmr_pkg::PMR_ADDR_LIL_FLAG, pmr_pkg::PMR_ADDR_BUV_FLAG,
		pmr_pkg::PMR_ADDR_BOV_FLAG, pmr_pkg::PMR_ADDR_LUV_FLAG};
	localparam logic [7:0] MASK_ADDR [G] = '{
		pmr_pkg::PMR_ADDR_SYS_MASK, pmr_pkg::PMR_ADDR_THM_MASK,
		pmr_pkg::PMR_ADDR_BMD_MASK, pmr_pkg::PMR_ADDR_BIL_MASK,
		pmr_pkg::PMR_ADDR_LIL_MASK, pmr_pkg::PMR_ADDR_BUV_MASK,
		pmr_pkg::PMR_ADDR_BOV_MASK, pmr_pkg::PMR_ADDR_LUV_MASK};
	localparam logic [7:0] USED [G] = '{
		pmr_pkg::PMR_USE_SYS_FLAG, pmr_pkg::PMR_USE_THM,
		pmr_pkg::PMR_USE_BUCK, pmr_pkg::PMR_USE_BUCK,
		pmr_pkg::PMR_USE_LDO, pmr_pkg::PMR_USE_BUCK,
		pmr_pkg::PMR_USE_BUCK, pmr_pkg::PMR_USE_LDO};

	logic [7:0] ev_vec   [G];
	logic [7:0] flag_vec [G];
	logic [7:0] mask_vec [G];
	logic [G-1:0] pend_vec;
	logic       group_clear;
	logic       wr_ok;
	logic [7:0] thm_events;

	// ----------------------------------------------------------------
	// reset classes and write permission
	// ----------------------------------------------------------------
	// event registers clear on undervoltage or off entry
	assign group_clear = ctl.uv_detect | ctl.off_entry;
	// host writes honoured only in powered-on states
	assign wr_ok = req.wr & ctl.system_on;

	// recovery completion latches the watchdog event flag
	always_comb begin
		thm_events = ev_thm;
		thm_events[pmr_pkg::PMR_WDOG_BIT] = ev_thm[pmr_pkg::PMR_WDOG_BIT]
			| soft_wdog_done;
	end

	assign ev_vec[0] = ev_sys;
	assign ev_vec[1] = thm_events;
	assign ev_vec[2] = ev_bmd;
	assign ev_vec[3] = ev_bil;
	assign ev_vec[4] = ev_lil;
	assign ev_vec[5] = ev_buv;
	assign ev_vec[6] = ev_bov;
	assign ev_vec[7] = ev_luv;

	// ----------------------------------------------------------------
	// event groups
	// ----------------------------------------------------------------
	for (genvar g = 0; g < G; g++) begin : gen_grp
		pmr_event_group #(
			.USED (USED[g])
		) u_grp (
			.clk_sys   (clk_sys),
			.reset_n   (reset_n),
			.clear_all (group_clear),
			.event_in  (ev_vec[g]),
			.flag_wr   (wr_ok && req.addr == FLAG_ADDR[g]),
			.mask_wr   (wr_ok && req.addr == MASK_ADDR[g]),
			.wdata     (req.wdata),
			.flag_reg  (flag_vec[g]),
			.mask_reg  (mask_vec[g]),
			.pending   (pend_vec[g])
		);
	end

	// ----------------------------------------------------------------
	// interrupt output, registered, active low
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			interrupt_out_n <= 1'b1;
		end else begin
			interrupt_out_n <= ~(|pend_vec);
		end
	end

	// ----------------------------------------------------------------
	// mirror of programmed defaults
	// ----------------------------------------------------------------
	logic [11:0] prog_num_reg;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prog_num_reg <= 12'h000;
		end else if (ctl.otp_load) begin
			prog_num_reg <= otp_program_number;
		end
	end

	// ----------------------------------------------------------------
	// trial-programmable setting, lost with backup supply
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			trial_setting <= pmr_pkg::PMR_ZERO_BYTE;
		end else if (ctl.backup_lost) begin
			trial_setting <= pmr_pkg::PMR_ZERO_BYTE;
		end else if (ctl.otp_load) begin
			trial_setting <= otp_trial_default;
		end else if (wr_ok && ctl.trial_mode
			&& req.addr == pmr_pkg::PMR_ADDR_REV) begin
			trial_setting <= req.wdata;
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [7:0] rd_next;

	always_comb begin
		rd_next = pmr_pkg::PMR_ZERO_BYTE;
		case (req.addr)
			pmr_pkg::PMR_ADDR_IDENT:
				rd_next = {pmr_pkg::PMR_FAMILY_CODE,
					pmr_pkg::PMR_PART_CODE};
			pmr_pkg::PMR_ADDR_REV:     rd_next = pmr_pkg::PMR_REVISION;
			pmr_pkg::PMR_ADDR_CFG_HIGH:
				rd_next = {prog_num_reg[11:8], 1'b0,
					pmr_pkg::PMR_CFG_REV};
			pmr_pkg::PMR_ADDR_CFG_LOW: rd_next = prog_num_reg[7:0];
			pmr_pkg::PMR_ADDR_SYS_FLAG: rd_next = flag_vec[0];
			pmr_pkg::PMR_ADDR_SYS_MASK: rd_next = mask_vec[0];
			pmr_pkg::PMR_ADDR_SYS_LIVE:
				rd_next = live_sys & pmr_pkg::PMR_USE_SYS_LIVE;
			pmr_pkg::PMR_ADDR_THM_FLAG: rd_next = flag_vec[1];
			pmr_pkg::PMR_ADDR_THM_MASK: rd_next = mask_vec[1];
			pmr_pkg::PMR_ADDR_THM_LIVE: rd_next = live_thm;
			pmr_pkg::PMR_ADDR_BMD_FLAG: rd_next = flag_vec[2];
			pmr_pkg::PMR_ADDR_BMD_MASK: rd_next = mask_vec[2];
			pmr_pkg::PMR_ADDR_BIL_FLAG: rd_next = flag_vec[3];
			pmr_pkg::PMR_ADDR_BIL_MASK: rd_next = mask_vec[3];
			pmr_pkg::PMR_ADDR_BIL_LIVE:
				rd_next = live_bil & pmr_pkg::PMR_USE_BUCK;
			pmr_pkg::PMR_ADDR_LIL_FLAG: rd_next = flag_vec[4];
			pmr_pkg::PMR_ADDR_LIL_MASK: rd_next = mask_vec[4];
			pmr_pkg::PMR_ADDR_LIL_LIVE:
				rd_next = live_lil & pmr_pkg::PMR_USE_LDO;
			pmr_pkg::PMR_ADDR_BUV_FLAG: rd_next = flag_vec[5];
			pmr_pkg::PMR_ADDR_BUV_MASK: rd_next = mask_vec[5];
			pmr_pkg::PMR_ADDR_BUV_LIVE:
				rd_next = live_buv & pmr_pkg::PMR_USE_BUCK;
			pmr_pkg::PMR_ADDR_BOV_FLAG: rd_next = flag_vec[6];
			pmr_pkg::PMR_ADDR_BOV_MASK: rd_next = mask_vec[6];
			pmr_pkg::PMR_ADDR_BOV_LIVE:
				rd_next = live_bov & pmr_pkg::PMR_USE_BUCK;
			pmr_pkg::PMR_ADDR_LUV_FLAG: rd_next = flag_vec[7];
			pmr_pkg::PMR_ADDR_LUV_MASK: rd_next = mask_vec[7];
			pmr_pkg::PMR_ADDR_LUV_LIVE:
				rd_next = live_luv & pmr_pkg::PMR_USE_LDO;
			default: rd_next = pmr_pkg::PMR_ZERO_BYTE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= pmr_pkg::PMR_ZERO_BYTE;
		end else if (req.rd) begin
			rdata <= rd_next;
		end
	end

endmodule : pmr_regs
`default_nettype wire

// ### rtl/pmr_pkg.sv
// constants and types for the identification and fault event register bank
package pmr_pkg;

	localparam int PMR_GROUPS = 8;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] PMR_ADDR_IDENT     = 8'h00;
	localparam logic [7:0] PMR_ADDR_REV       = 8'h01;
	localparam logic [7:0] PMR_ADDR_CFG_HIGH  = 8'h02;
	localparam logic [7:0] PMR_ADDR_CFG_LOW   = 8'h03;
	localparam logic [7:0] PMR_ADDR_SYS_FLAG  = 8'h04;
	localparam logic [7:0] PMR_ADDR_SYS_MASK  = 8'h05;
	localparam logic [7:0] PMR_ADDR_SYS_LIVE  = 8'h06;
	localparam logic [7:0] PMR_ADDR_THM_FLAG  = 8'h07;
	localparam logic [7:0] PMR_ADDR_THM_MASK  = 8'h08;
	localparam logic [7:0] PMR_ADDR_THM_LIVE  = 8'h09;
	localparam logic [7:0] PMR_ADDR_BMD_FLAG  = 8'h0A;
	localparam logic [7:0] PMR_ADDR_BMD_MASK  = 8'h0B;
	localparam logic [7:0] PMR_ADDR_BIL_FLAG  = 8'h12;
	localparam logic [7:0] PMR_ADDR_BIL_MASK  = 8'h13;
	localparam logic [7:0] PMR_ADDR_BIL_LIVE  = 8'h14;
	localparam logic [7:0] PMR_ADDR_LIL_FLAG  = 8'h15;
	localparam logic [7:0] PMR_ADDR_LIL_MASK  = 8'h16;
	localparam logic [7:0] PMR_ADDR_LIL_LIVE  = 8'h17;
	localparam logic [7:0] PMR_ADDR_BUV_FLAG  = 8'h18;
	localparam logic [7:0] PMR_ADDR_BUV_MASK  = 8'h19;
	localparam logic [7:0] PMR_ADDR_BUV_LIVE  = 8'h1A;
	localparam logic [7:0] PMR_ADDR_BOV_FLAG  = 8'h1B;
	localparam logic [7:0] PMR_ADDR_BOV_MASK  = 8'h1C;
	localparam logic [7:0] PMR_ADDR_BOV_LIVE  = 8'h1D;
	localparam logic [7:0] PMR_ADDR_LUV_FLAG  = 8'h1E;
	localparam logic [7:0] PMR_ADDR_LUV_MASK  = 8'h1F;
	localparam logic [7:0] PMR_ADDR_LUV_LIVE  = 8'h20;

	// ----------------------------------------------------------------
	// implemented bits per event group (unused read zero)
	// ----------------------------------------------------------------
	localparam logic [7:0] PMR_USE_SYS_FLAG = 8'hFF;
	localparam logic [7:0] PMR_USE_SYS_LIVE = 8'h07;
	localparam logic [7:0] PMR_USE_THM      = 8'hFF;
	localparam logic [7:0] PMR_USE_BUCK     = 8'h7F;
	localparam logic [7:0] PMR_USE_LDO      = 8'h0F;
	localparam logic [7:0] PMR_USE_NONE     = 8'h00;

	// watchdog event flag position in the thermal group
	localparam int         PMR_WDOG_BIT     = 7;
	// reset values of masks: all sources masked
	localparam logic [7:0] PMR_MASK_RESET   = 8'hFF;
	localparam logic [7:0] PMR_ZERO_BYTE    = 8'h00;

	// identity values, arbitrary
	localparam logic [3:0] PMR_FAMILY_CODE  = 4'hA;
	localparam logic [3:0] PMR_PART_CODE    = 4'h5;
	localparam logic [7:0] PMR_REVISION     = 8'h11;
	localparam logic [2:0] PMR_CFG_REV      = 3'h1;

	typedef logic [2:0] pmr_grp_t;

	// ----------------------------------------------------------------
	// grouped signals
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pmr_req_s;

	typedef struct packed {
		logic        uv_detect;
		logic        off_entry;
		logic        backup_lost;
		logic        trial_mode;
		logic        system_on;
		logic        otp_load;
	} pmr_ctl_s;

endpackage : pmr_pkg

// ### rtl/pmr_event_group.sv
// one latched event group: flag and mask bytes
`timescale 1ns/1ps
`default_nettype none
module pmr_event_group #(
	parameter logic [7:0] USED = 8'hFF
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	// group reset from reset classes
	input  wire logic       clear_all,
	// event sources
	input  wire logic [7:0] event_in,
	// register writes
	input  wire logic       flag_wr,
	input  wire logic       mask_wr,
	input  wire logic [7:0] wdata,
	// state
	output logic      [7:0] flag_reg,
	output logic      [7:0] mask_reg,
	output logic            pending
);

	// ----------------------------------------------------------------
	// latched flags, set beats write-one clear, group clear beats set
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			flag_reg <= pmr_pkg::PMR_ZERO_BYTE;
		end else if (clear_all) begin
			flag_reg <= pmr_pkg::PMR_ZERO_BYTE;
		end else begin
			flag_reg <= ((flag_reg & ~(flag_wr ? wdata : 8'h00))
				| event_in) & USED;
		end
	end

	// ----------------------------------------------------------------
	// mask
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mask_reg <= pmr_pkg::PMR_MASK_RESET & USED;
		end else if (clear_all) begin
			mask_reg <= pmr_pkg::PMR_MASK_RESET & USED;
		end else if (mask_wr) begin
			mask_reg <= wdata & USED;
		end
	end

	assign pending = |(flag_reg & ~mask_reg);

endmodule : pmr_event_group
`default_nettype wire

// ### testbench/pmr_regs_monitor.sv
// assertion checker on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module pmr_regs_monitor (
	// clock and reset
	input wire logic              clk_sys,
	input wire logic              reset_n,
	// register port
	input wire pmr_pkg::pmr_req_s req,
	input wire logic [7:0]        rdata,
	// state and outputs
	input wire pmr_pkg::pmr_ctl_s ctl,
	input wire logic [7:0]        trial_setting,
	input wire logic              interrupt_out_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	a_ident_read: assert property (
		req.rd && req.addr == 8'h00 |=> rdata ==
		{pmr_pkg::PMR_FAMILY_CODE, pmr_pkg::PMR_PART_CODE})
		else $error("identification read wrong");
	a_cfg_high: assert property (
		req.rd && req.addr == 8'h02 |=>
		rdata[3:0] == {1'b0, pmr_pkg::PMR_CFG_REV})
		else $error("program high low nibble wrong");
	a_unmapped_zero: assert property (
		req.rd && req.addr == 8'h0C |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (
		!req.rd |=> $stable(rdata))
		else $error("read data moved without read");
	a_trial_locked: assert property (
		!ctl.trial_mode && !ctl.otp_load && !ctl.backup_lost
		|=> $stable(trial_setting))
		else $error("trial byte changed outside trial mode");
	a_trial_write: assert property (
		req.wr && req.addr == 8'h01 && ctl.trial_mode && ctl.system_on
		&& !ctl.otp_load && !ctl.backup_lost
		|=> trial_setting == $past(req.wdata))
		else $error("trial byte write lost");
	a_backup_clear: assert property (
		ctl.backup_lost && !ctl.otp_load |=> trial_setting == 8'h00)
		else $error("trial byte kept after backup loss");
	a_uv_clear: assert property (
		ctl.uv_detect [*2] |=> interrupt_out_n)
		else $error("interrupt kept after undervoltage");
	a_off_clear: assert property (
		ctl.off_entry [*2] |=> interrupt_out_n)
		else $error("interrupt kept after off entry");
endmodule : pmr_regs_monitor

bind pmr_regs pmr_regs_monitor u_mon (.clk_sys(clk_sys),
	.reset_n(reset_n), .req(req), .rdata(rdata), .ctl(ctl),
	.trial_setting(trial_setting), .interrupt_out_n(interrupt_out_n));
`default_nettype wire

// ### testbench/pmr_host_model.sv
// host controller model issuing register requests
`timescale 1ns/1ps
`default_nettype none
module pmr_host_model (
	// clock
	input wire logic             clk_sys,
	// register request
	output var pmr_pkg::pmr_req_s req
);
	initial req = '0;
	// one request, one cycle, taken at the next edge
	task automatic xfer(input logic w, input logic [7:0] a, d);
		@(posedge clk_sys);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk_sys);
		req <= '0;
		#1;
	endtask : xfer
endmodule : pmr_host_model
`default_nettype wire

// ### testbench/test_pmr_regs.sv
// testbench for the register bank
`timescale 1ns/1ps
`default_nettype none
module test_pmr_regs;
	logic              clk_sys, reset_n, wdog;
	pmr_pkg::pmr_req_s req;
	pmr_pkg::pmr_ctl_s ctl;
	logic [7:0]        rdata, trial_setting, v;
	logic [7:0]        ev [8];
	logic [7:0]        lv [7];
	logic              irq_n;
	int                bad_count, checks;

	pmr_host_model host (.clk_sys(clk_sys), .req(req));
	pmr_regs dut (.clk_sys(clk_sys), .reset_n(reset_n), .req(req),
		.rdata(rdata), .ctl(ctl), .otp_program_number(12'h9C3),
		.otp_trial_default(8'h3C), .ev_sys(ev[0]), .ev_thm(ev[1]),
		.ev_bmd(ev[2]), .ev_bil(ev[3]), .ev_lil(ev[4]), .ev_buv(ev[5]),
		.ev_bov(ev[6]), .ev_luv(ev[7]), .soft_wdog_done(wdog),
		.live_sys(lv[0]), .live_thm(lv[1]), .live_bil(lv[2]),
		.live_lil(lv[3]), .live_buv(lv[4]), .live_bov(lv[5]),
		.live_luv(lv[6]), .trial_setting(trial_setting),
		.interrupt_out_n(irq_n));

	task automatic check(input string n, input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic rd(input logic [7:0] a, e);
		host.xfer(1'b0, a, 8'h00);
		check("rdata", rdata, e);
	endtask : rd
	task automatic wr(input logic [7:0] a, d);
		host.xfer(1'b1, a, d);
	endtask : wr
	task automatic pulse(input int i, input logic [7:0] b);
		@(posedge clk_sys);
		ev[i] <= b;
		@(posedge clk_sys);
		ev[i] <= 8'h00;
	endtask : pulse
	task automatic irq(input logic e);
		repeat (2) @(posedge clk_sys);
		#1 check("irq_n", {7'h00, irq_n}, {7'h00, e});
	endtask : irq
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_ident;
		@(posedge clk_sys);
		lv[0] <= 8'hFF;
		rd(8'h00, {pmr_pkg::PMR_FAMILY_CODE, pmr_pkg::PMR_PART_CODE});
		rd(8'h01, pmr_pkg::PMR_REVISION);
		rd(8'h02, {4'h9, 1'b0, pmr_pkg::PMR_CFG_REV});
		rd(8'h03, 8'hC3);
		rd(8'h0C, 8'h00);
		rd(8'h08, 8'hFF);
		rd(8'h06, 8'h07);
	endtask : t_ident
	task automatic t_events;
		wr(8'h05, 8'hFE);
		@(posedge clk_sys);
		ctl.system_on <= 1'b0;
		wr(8'h05, 8'hFF);
		@(posedge clk_sys);
		ctl.system_on <= 1'b1;
		rd(8'h05, 8'hFE);
		pulse(0, 8'h01);
		irq(1'b0);
		wr(8'h04, 8'h00);
		rd(8'h04, 8'h01);
		wr(8'h04, 8'h01);
		rd(8'h04, 8'h00);
		irq(1'b1);
	endtask : t_events
	task automatic t_unused;
		wr(8'h16, 8'h00);
		rd(8'h16, 8'h00);
		wr(8'h16, 8'hFF);
		rd(8'h16, 8'h0F);
		pulse(4, 8'hFF);
		rd(8'h15, 8'h0F);
	endtask : t_unused
	task automatic t_trial;
		check("trial", trial_setting, 8'h3C);
		wr(8'h01, 8'h55);
		check("trial", trial_setting, 8'h3C);
		@(posedge clk_sys);
		ctl.trial_mode <= 1'b1;
		wr(8'h01, 8'h55);
		check("trial", trial_setting, 8'h55);
		@(posedge clk_sys);
		ctl.backup_lost <= 1'b1;
		ctl.trial_mode <= 1'b0;
		@(posedge clk_sys);
		ctl.backup_lost <= 1'b0;
		#1 check("trial", trial_setting, 8'h00);
	endtask : t_trial
	task automatic t_clear;
		for (int i = 0; i < 2; i++) begin
			wr(8'h05, 8'hFE);
			pulse(0, 8'h01);
			irq(1'b0);
			@(posedge clk_sys);
			if (i == 0) ctl.uv_detect <= 1'b1;
			else ctl.off_entry <= 1'b1;
			repeat (2) @(posedge clk_sys);
			ctl.uv_detect <= 1'b0;
			ctl.off_entry <= 1'b0;
			irq(1'b1);
			rd(8'h05, 8'hFF);
			rd(8'h04, 8'h00);
		end
	endtask : t_clear
	task automatic t_wdog;
		wr(8'h08, 8'h7F);
		@(posedge clk_sys);
		wdog <= 1'b1;
		@(posedge clk_sys);
		wdog <= 1'b0;
		irq(1'b0);
		rd(8'h07, 8'h80);
	endtask : t_wdog
	task automatic t_live;
		wr(pmr_pkg::PMR_ADDR_THM_FLAG, 8'h80);
		irq(1'b1);
		@(posedge clk_sys);
		foreach (lv[i]) lv[i] <= 8'hFF;
		rd(8'h09, 8'hFF);
		rd(8'h14, pmr_pkg::PMR_USE_BUCK);
		rd(8'h17, pmr_pkg::PMR_USE_LDO);
		rd(8'h1A, pmr_pkg::PMR_USE_BUCK);
		rd(8'h1D, pmr_pkg::PMR_USE_BUCK);
		rd(8'h20, pmr_pkg::PMR_USE_LDO);
	endtask : t_live
	task automatic t_group(input int i, input logic [7:0] fa, u);
		pulse(i, 8'hFF);
		irq(1'b1);
		rd(fa, u);
		rd(fa + 8'h01, u);
		wr(fa + 8'h01, 8'hFE);
		irq(1'b0);
		@(posedge clk_sys);
		ev[i] <= 8'h01;
		wr(fa, u);
		@(posedge clk_sys);
		ev[i] <= 8'h00;
		rd(fa, 8'h01);
		wr(fa, 8'h01);
		rd(fa, 8'h00);
		irq(1'b1);
	endtask : t_group

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		reset_n = 1'b0;
		wdog = 1'b0;
		ctl = '0;
		ctl.system_on = 1'b1;
		ctl.otp_load = 1'b1;
		foreach (ev[i]) ev[i] = 8'h00;
		foreach (lv[i]) lv[i] = 8'h00;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		ctl.otp_load <= 1'b0;
		t_ident();
		t_events();
		t_unused();
		t_trial();
		t_clear();
		t_wdog();
		t_live();
		t_group(2, pmr_pkg::PMR_ADDR_BMD_FLAG, pmr_pkg::PMR_USE_BUCK);
		t_group(3, pmr_pkg::PMR_ADDR_BIL_FLAG, pmr_pkg::PMR_USE_BUCK);
		t_group(4, pmr_pkg::PMR_ADDR_LIL_FLAG, pmr_pkg::PMR_USE_LDO);
		t_group(5, pmr_pkg::PMR_ADDR_BUV_FLAG, pmr_pkg::PMR_USE_BUCK);
		t_group(6, pmr_pkg::PMR_ADDR_BOV_FLAG, pmr_pkg::PMR_USE_BUCK);
		t_group(7, pmr_pkg::PMR_ADDR_LUV_FLAG, pmr_pkg::PMR_USE_LDO);
		print_verdict();
	end
endmodule : test_pmr_regs
`default_nettype wire
